// >>> pmc_controller.sv
`timescale 1ns/1ps
// --------------------------------------------------------------------------
// Global power-mode controller
// --------------------------------------------------------------------------
module pmc_controller #(
    parameter int RESUME_COUNT = pmc_pkg::RESUME_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_clock_enable,
    // Firmware control.
    input wire logic i_mode_req_valid,
    input wire pmc_pkg::pmc_mode_t i_mode_req,
    input wire logic [pmc_pkg::SUBSYS_W-1:0] i_active_template,
    input wire logic [pmc_pkg::SUBSYS_W-1:0] i_alt_template,
    input wire logic i_cpu_self_off,
    input wire logic [pmc_pkg::WAKE_W-1:0] i_wake_enable,
    input wire logic i_reg_disable,
    // Supply and wake sources.
    input wire logic i_ext_core_supply,
    input wire logic i_io_supply_valid,
    input wire logic [pmc_pkg::WAKE_W-1:0] i_int_wake,
    input wire logic i_pin_interrupt_unit,
    input wire logic i_periodic_wake_timer,
    input wire logic i_reset_wake,
    // Outputs.
    output logic [pmc_pkg::SUBSYS_W-1:0] o_clock_gate_en,
    output logic [pmc_pkg::SUBSYS_W-1:0] o_bias_en,
    output logic o_cpu_enable,
    output logic o_slow_clock_run,
    output logic o_rtc_run,
    output logic o_all_clocks_stop,
    output logic o_pin_wake_only,
    output pmc_pkg::pmc_reg_ctrl_t o_regulators,
    output pmc_pkg::pmc_mode_t o_mode,
    output logic o_resuming,
    output logic o_wake_event
);
    import pmc_pkg::*;

    // Refuse a settle count that the resume counter cannot serve.
    if (RESUME_COUNT < 1) begin : gen_bad_resume
        $error("RESUME_COUNT must be at least one cycle.");
    end

    // ----------------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------------
    // The external-supply strap is a board level, so it is synchronised like the
    // wake pins; it only changes slowly, so the two-cycle lag costs nothing.
    localparam int ASYNC_W = WAKE_W + 5;
    logic [ASYNC_W-1:0] async_in;
    logic [ASYNC_W-1:0] sync_out;
    logic [WAKE_W-1:0] int_wake_s;
    logic pin_wake_s;
    logic timer_wake_s;
    logic reset_wake_s;
    logic io_valid_s;
    logic ext_supply_s;

    assign async_in = {i_int_wake, i_pin_interrupt_unit, i_periodic_wake_timer,
                       i_reset_wake, i_io_supply_valid, i_ext_core_supply};

    pmc_sync #(.WIDTH(ASYNC_W)) u_sync (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_enable(i_clock_enable),
        .i_async(async_in),
        .o_sync(sync_out)
    );

    assign int_wake_s = sync_out[ASYNC_W-1 -: WAKE_W];
    assign pin_wake_s = sync_out[4];
    assign timer_wake_s = sync_out[3];
    assign reset_wake_s = sync_out[2];
    assign io_valid_s = sync_out[1];
    assign ext_supply_s = sync_out[0];

    // ----------------------------------------------------------------------
    // Wakeup qualification
    // ----------------------------------------------------------------------
    logic wake_sleep;
    logic wake_hib;
    logic wake_any;
    logic next_wake_level;
    logic wake_level;

    // Hibernate has no running clocks to any source but the pins and the reset wake.
    always_comb begin
        wake_sleep = (|(int_wake_s & i_wake_enable)) || timer_wake_s
                     || pin_wake_s || reset_wake_s; // see R17 R10
        wake_hib = pin_wake_s || reset_wake_s; // see R13
        case (o_mode)
            PMC_SLEEP: next_wake_level = wake_sleep;
            PMC_HIBERNATE: next_wake_level = wake_hib;
            default: next_wake_level = wake_sleep;
        endcase
    end

    // Edge of the qualified wake level forms one wakeup event.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wake_level <= 1'b0;
        end else if (i_clock_enable) begin
            wake_level <= next_wake_level;
        end
    end

    assign wake_any = next_wake_level && !wake_level;

    // ----------------------------------------------------------------------
    // Mode state machine
    // ----------------------------------------------------------------------
    localparam int RESUME_W = $clog2(RESUME_COUNT + 1);
    localparam logic [RESUME_W-1:0] RESUME_LAST = RESUME_W'(RESUME_COUNT - 1);
    logic [RESUME_W-1:0] resume_cnt;
    logic resume_done;
    logic req_ok;

    // Low-power requests are ignored until the I/O supplies are valid.
    assign req_ok = i_mode_req_valid
                    && ((i_mode_req == PMC_ACTIVE) || (i_mode_req == PMC_ALT_ACTIVE)
                        || io_valid_s); // see R15

    // Terminal count of the settle wait that follows a wake from sleep.
    assign resume_done = o_resuming && (resume_cnt == RESUME_LAST);

    // The settle wait has its own counter so that the mode logic stays a plain decode.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_resuming <= 1'b0;
            resume_cnt <= '0;
        end else if (i_clock_enable) begin
            if (resume_done) begin
                o_resuming <= 1'b0; // see R12
            end else if (o_resuming) begin
                resume_cnt <= resume_cnt + 1'b1;
            end else if (o_mode == PMC_SLEEP && wake_any) begin
                o_resuming <= 1'b1;
                resume_cnt <= '0;
            end
        end
    end

    // Wakeups win over requests; in the low-power modes requests are ignored.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_mode <= PMC_ACTIVE; // see R7
        end else if (i_clock_enable) begin
            case (o_mode)
                PMC_ACTIVE, PMC_ALT_ACTIVE: begin
                    if (wake_any) begin
                        o_mode <= PMC_ACTIVE; // see R6
                    end else if (req_ok) begin
                        o_mode <= i_mode_req; // see R1 R18
                    end
                end
                PMC_SLEEP: begin
                    // Regulators leave buzz at once but the core waits to settle.
                    if (resume_done) begin
                        o_mode <= PMC_ACTIVE; // see R12
                    end
                end
                PMC_HIBERNATE: begin
                    if (wake_any) begin
                        o_mode <= PMC_ACTIVE; // see R13 R6
                    end
                end
                default: o_mode <= PMC_ACTIVE;
            endcase
        end
    end

    // A frozen block reports no events, since it would not act on them either;
    // the level detector holds its state, so the event shows once enable returns.
    assign o_wake_event = wake_any && i_clock_enable; // see R17

    // ----------------------------------------------------------------------
    // CPU self-disable
    // ----------------------------------------------------------------------
    logic cpu_off;

    // Wakeup wins over a simultaneous self-off so the event is not lost.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cpu_off <= 1'b0;
        end else if (i_clock_enable) begin
            if (wake_any) begin
                cpu_off <= 1'b0; // see R5
            end else if (i_cpu_self_off) begin
                cpu_off <= 1'b1; // see R5
            end
        end
    end

    // ----------------------------------------------------------------------
    // Subsystem enables
    // ----------------------------------------------------------------------
    logic [SUBSYS_W-1:0] next_enables;
    logic wake_force_cpu;

    // CPU forced on for the remainder of active after a wake, until a self-off or an accepted mode request.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wake_force_cpu <= 1'b0;
        end else if (i_clock_enable) begin
            if (wake_any) begin
                wake_force_cpu <= 1'b1; // see R6
            end else if (i_cpu_self_off || req_ok) begin
                wake_force_cpu <= 1'b0;
            end
        end
    end

    // Templates are read live so firmware edits act on the next cycle.
    always_comb begin
        case (o_mode)
            PMC_ACTIVE: next_enables = i_active_template; // see R2 R4
            PMC_ALT_ACTIVE: next_enables = i_alt_template; // see R8 R4
            PMC_SLEEP: next_enables = '0; // see R9
            PMC_HIBERNATE: next_enables = '0; // see R13
            default: next_enables = '0;
        endcase
        if (o_mode == PMC_ACTIVE || o_mode == PMC_ALT_ACTIVE) begin
            if (cpu_off) begin
                next_enables[CPU_BIT] = 1'b0; // see R5
            end
            if (wake_force_cpu && !cpu_off) begin
                next_enables[CPU_BIT] = 1'b1; // see R6
            end
        end
    end

    // Registered so gating changes never glitch the subsystem clocks.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_clock_gate_en <= ACT_TMPL_RESET;
            o_bias_en <= ACT_TMPL_RESET;
            o_cpu_enable <= 1'b1;
        end else if (i_clock_enable) begin
            o_clock_gate_en <= next_enables; // see R3
            o_bias_en <= next_enables; // see R3
            o_cpu_enable <= next_enables[CPU_BIT];
        end
    end

    // ----------------------------------------------------------------------
    // Clocks and regulators
    // ----------------------------------------------------------------------
    logic reg_disabled;
    logic core_regs_on;
    logic core_regs_buzz;
    pmc_reg_ctrl_t next_regulators;

    // Internal regulators start enabled even when the core is fed externally.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            reg_disabled <= 1'b0; // see R16
        end else if (i_clock_enable) begin
            reg_disabled <= i_reg_disable && ext_supply_s; // see R16
        end
    end

    // Only hibernate stops the slow clocks; sleep relies on them for timed wakes.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_slow_clock_run <= 1'b1;
            o_rtc_run <= 1'b1;
            o_all_clocks_stop <= 1'b0;
            o_pin_wake_only <= 1'b0;
        end else if (i_clock_enable) begin
            o_slow_clock_run <= (o_mode != PMC_HIBERNATE); // see R10
            o_rtc_run <= (o_mode != PMC_HIBERNATE); // see R10
            o_all_clocks_stop <= (o_mode == PMC_HIBERNATE); // see R13
            o_pin_wake_only <= (o_mode == PMC_HIBERNATE); // see R13
        end
    end

    // Buzzing lasts only while sleep is settled, so that a resume has full-duty
    // regulators from the second cycle of the settle wait to its end.
    assign core_regs_on = (o_mode != PMC_HIBERNATE) && !reg_disabled; // see R14 R16
    assign core_regs_buzz = (o_mode == PMC_SLEEP) && !o_resuming; // see R11

    // The hibernate regulator never turns off: it keeps retention alive in every mode.
    always_comb begin
        next_regulators = REG_CTRL_RESET;
        next_regulators.hibernate_on = 1'b1; // see R14
        next_regulators.digital_on = core_regs_on;
        next_regulators.analog_on = core_regs_on;
        next_regulators.digital_buzz = core_regs_buzz;
        next_regulators.analog_buzz = core_regs_buzz;
    end

    // Registered so that a mode change moves all regulator controls on one edge.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_regulators <= REG_CTRL_RESET; // see R16
        end else if (i_clock_enable) begin
            o_regulators <= next_regulators;
        end
    end

endmodule : pmc_controller

// >>> pmc_pkg.sv
// Overview of operation
// R1: Four global modes ranked active, alternate active, sleep, hibernate.
// R2: In active mode each subsystem follows its own active template bit.
// R3: A disabled subsystem has its clock gated and analog bias shut off.
// R4: Template bit changes take effect immediately while running.
// R5: CPU may switch itself off; next wakeup turns it back on.
// R6: Wakeup forces active mode and enables CPU regardless of template.
// R7: Global mode is active after reset.
// R8: Alternate active uses a separate, smaller subsystem template.
// R9: Sleep disables most resources regardless of templates.
// R10: Sleep keeps wake timer and real-time clock running on slow clocks.
// R11: Sleep puts digital and analog core regulators in buzzed state.
// R12: Resume from sleep waits about 15 us for regulators to settle.
// R13: Hibernate stops all clocks, retains state, wakes only from pins. (The code also wakes on the reset wake.)
// R14: Hibernate turns off all regulators except the hibernate regulator.
// R15: Firmware requests sleep or hibernate only with valid I/O supplies.
// R16: With external core supply, internal regulators start enabled by default.
// R17: Wakeup sources are enabled interrupts or resets, each restores active.
// R18: Current global mode is readable as status.
package pmc_pkg;

    // ------------------------------------------------------------------
    // Modes and subsystem layout
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PMC_ACTIVE,
        PMC_ALT_ACTIVE,
        PMC_SLEEP,
        PMC_HIBERNATE
    } pmc_mode_t;

    localparam int SUBSYS_W = 8;
    localparam int CPU_BIT = 0;
    localparam int FLASH_BIT = 1;
    localparam int WAKE_W = 8;

    // Reset values: everything on in active, all but CPU and flash in alternate.
    localparam logic [SUBSYS_W-1:0] ACT_TMPL_RESET = 8'h00_FF;
    localparam logic [SUBSYS_W-1:0] ALT_TMPL_RESET = 8'h00_FC;
    localparam logic [WAKE_W-1:0] WAKE_EN_RESET = 8'h00_FF;

    // Sleep resume settle time.
    localparam int RESUME_NS = 15000;
    localparam int CLOCK_PERIOD_NS = 4;
    localparam int RESUME_CYCLES = (RESUME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    // Regulator controls travel together.
    typedef struct packed {
        logic digital_on;
        logic digital_buzz;
        logic analog_on;
        logic analog_buzz;
        logic hibernate_on;
    } pmc_reg_ctrl_t;

    // Regulators after reset: both core regulators on at full duty, hibernate on.
    localparam pmc_reg_ctrl_t REG_CTRL_RESET = '{digital_on: 1'b1, digital_buzz: 1'b0,
        analog_on: 1'b1, analog_buzz: 1'b0, hibernate_on: 1'b1};

endpackage : pmc_pkg

// >>> pmc_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for a bundle of asynchronous levels.
module pmc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_enable,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] stage1;

    // The first stage feeds only the second, to contain metastability.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            stage1 <= '0;
            o_sync <= '0;
        end else if (i_enable) begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end

endmodule : pmc_sync

// >>> pmc_controller_asserts.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port-level checker for the power-mode controller
// ----------------------------------------------------------------
module pmc_controller_asserts #(
    parameter int RESUME_COUNT = pmc_pkg::RESUME_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_clock_enable,
    input wire logic i_mode_req_valid,
    input wire pmc_pkg::pmc_mode_t i_mode_req,
    input wire logic [pmc_pkg::SUBSYS_W-1:0] i_active_template,
    input wire logic [pmc_pkg::SUBSYS_W-1:0] i_alt_template,
    input wire logic i_cpu_self_off,
    input wire logic [pmc_pkg::SUBSYS_W-1:0] o_clock_gate_en,
    input wire logic [pmc_pkg::SUBSYS_W-1:0] o_bias_en,
    input wire logic o_cpu_enable,
    input wire logic o_slow_clock_run,
    input wire logic o_rtc_run,
    input wire logic o_all_clocks_stop,
    input wire logic o_pin_wake_only,
    input wire pmc_pkg::pmc_reg_ctrl_t o_regulators,
    input wire pmc_pkg::pmc_mode_t o_mode,
    input wire logic o_resuming,
    input wire logic o_wake_event
);
    import pmc_pkg::*;
    // Cycles spent in the sleep settle wait; a counter keeps long waits cheap.
    int resume_run;
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            resume_run <= 0;
        end else if (!o_resuming) begin
            resume_run <= 0;
        end else if (i_clock_enable) begin
            resume_run <= resume_run + 1;
        end
    end

    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);

    // Bit 0 is left out of the template checks because a wake forces the CPU on.
    AST_RESET_MODE: assert property ($rose(i_reset_n) |-> o_mode == PMC_ACTIVE && o_cpu_enable)
        else $error("mode after reset is not active");
    AST_ACT_GATE: assert property ($past(i_reset_n) && $past(i_clock_enable)
        && $past(o_mode) == PMC_ACTIVE |->
        o_clock_gate_en[SUBSYS_W-1:1] == $past(i_active_template[SUBSYS_W-1:1]))
        else $error("active gates differ from active template");
    AST_ALT_GATE: assert property ($past(i_reset_n) && $past(i_clock_enable)
        && $past(o_mode) == PMC_ALT_ACTIVE |->
        o_clock_gate_en[SUBSYS_W-1:1] == $past(i_alt_template[SUBSYS_W-1:1]))
        else $error("alternate gates differ from alternate template");
    AST_BIAS: assert property (o_bias_en == o_clock_gate_en)
        else $error("bias enable differs from clock gate");
    AST_SLEEP: assert property ($past(o_mode) == PMC_SLEEP && o_mode == PMC_SLEEP
        && !o_resuming && !$past(o_resuming) |-> o_clock_gate_en == '0
        && o_regulators.digital_buzz && o_regulators.analog_buzz
        && o_slow_clock_run && o_rtc_run)
        else $error("sleep outputs wrong");
    AST_HIB: assert property ($past(o_mode) == PMC_HIBERNATE && o_mode == PMC_HIBERNATE
        |-> o_all_clocks_stop && o_pin_wake_only && !o_regulators.digital_on
        && !o_regulators.analog_on && o_regulators.hibernate_on)
        else $error("hibernate outputs wrong");
    AST_HIB_WAKE: assert property (o_mode == PMC_HIBERNATE && o_wake_event
        |=> o_mode == PMC_ACTIVE ##1 o_cpu_enable && o_regulators.digital_on)
        else $error("hibernate wake did not restore active");
    AST_SLEEP_WAKE: assert property (o_mode == PMC_SLEEP && o_wake_event && !o_resuming
        |=> o_resuming)
        else $error("sleep wake did not start the resume wait");
    AST_RESUME_LEN: assert property (o_resuming |-> resume_run < RESUME_COUNT)
        else $error("sleep resume too long");
    AST_RESUME_END: assert property ($fell(o_resuming) |-> o_mode == PMC_ACTIVE)
        else $error("resume wait ended outside active mode");
    AST_SELF_OFF: assert property (o_mode == PMC_ACTIVE && i_cpu_self_off && i_clock_enable
        && !o_wake_event && !i_mode_req_valid ##1 i_clock_enable |=> !o_cpu_enable)
        else $error("cpu stayed on after self off");
    AST_REQ_ALT: assert property (o_mode == PMC_ACTIVE && i_mode_req_valid && i_clock_enable
        && i_mode_req == PMC_ALT_ACTIVE && !o_wake_event |=> o_mode == PMC_ALT_ACTIVE)
        else $error("alternate request not taken");

    // Main scenarios that the bench should reach.
    COV_SLEEP_WAKE: cover property (o_mode == PMC_SLEEP && o_wake_event);
    COV_HIB_WAKE: cover property (o_mode == PMC_HIBERNATE && o_wake_event);
    COV_SELF_OFF: cover property ($fell(o_cpu_enable));
endmodule : pmc_controller_asserts

bind pmc_controller pmc_controller_asserts #(.RESUME_COUNT(RESUME_COUNT)) pmc_controller_asserts_i (
    .i_clock, .i_reset_n, .i_clock_enable, .i_mode_req_valid, .i_mode_req,
    .i_active_template, .i_alt_template, .i_cpu_self_off, .o_clock_gate_en, .o_bias_en,
    .o_cpu_enable, .o_slow_clock_run, .o_rtc_run, .o_all_clocks_stop, .o_pin_wake_only,
    .o_regulators, .o_mode, .o_resuming, .o_wake_event
);

// >>> test_pmc_controller.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bench for the power-mode controller
// ----------------------------------------------------------------
module test_pmc_controller;
    import pmc_pkg::*;
    // A short resume count keeps the run brief.
    localparam int RESUME = 4;
    logic i_clock = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_clock_enable = 1'b1;
    logic i_mode_req_valid = 1'b0;
    pmc_mode_t i_mode_req = PMC_ACTIVE;
    logic [SUBSYS_W-1:0] i_active_template = 8'hFF;
    logic [SUBSYS_W-1:0] i_alt_template = 8'hFC;
    logic [WAKE_W-1:0] i_wake_enable = 8'hFF;
    logic [WAKE_W-1:0] i_int_wake = 8'h00;
    logic i_cpu_self_off = 1'b0;
    logic i_reg_disable = 1'b0;
    logic i_ext_core_supply = 1'b0;
    logic i_io_supply_valid = 1'b1;
    logic i_pin_interrupt_unit = 1'b0;
    logic i_periodic_wake_timer = 1'b0;
    logic i_reset_wake = 1'b0;
    logic [SUBSYS_W-1:0] o_clock_gate_en, o_bias_en;
    logic o_cpu_enable, o_slow_clock_run, o_rtc_run, o_all_clocks_stop;
    logic o_pin_wake_only, o_resuming, o_wake_event;
    pmc_reg_ctrl_t o_regulators;
    pmc_mode_t o_mode;
    int bad_count = 0;
    int checked = 0;
    int n;

    pmc_controller #(.RESUME_COUNT(RESUME)) pmc_controller_i (
        .i_clock, .i_reset_n, .i_clock_enable, .i_mode_req_valid, .i_mode_req,
        .i_active_template, .i_alt_template, .i_cpu_self_off, .i_wake_enable,
        .i_reg_disable, .i_ext_core_supply, .i_io_supply_valid, .i_int_wake,
        .i_pin_interrupt_unit, .i_periodic_wake_timer, .i_reset_wake, .o_clock_gate_en,
        .o_bias_en, .o_cpu_enable, .o_slow_clock_run, .o_rtc_run, .o_all_clocks_stop,
        .o_pin_wake_only, .o_regulators, .o_mode, .o_resuming, .o_wake_event
    );

    // 250 MHz clock.
    always #2 i_clock = ~i_clock;

    // Compare and count; a mismatch is reported at once.
    task chk(input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk

    // Step past a number of edges so that their updates have landed.
    task cyc(input int k);
        repeat (k) @(posedge i_clock);
        #1;
    endtask : cyc

    // One-cycle mode request, then time for mode and enables to follow.
    task req(input pmc_mode_t m);
        @(posedge i_clock);
        i_mode_req_valid <= 1'b1;
        i_mode_req <= m;
        @(posedge i_clock);
        i_mode_req_valid <= 1'b0;
        cyc(3);
    endtask : req

    // Bounded wait for active mode; n holds the cycles spent.
    task to_active;
        n = 0;
        while (o_mode !== PMC_ACTIVE && n < 60) begin
            cyc(1);
            n++;
        end
    endtask : to_active

    task conclude;
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude

    // Main sequence.
    initial begin
        repeat (16) @(posedge i_clock);
        i_reset_n <= 1'b1;
        cyc(3);
        chk(8'(o_mode), 8'h00);
        chk(o_clock_gate_en, 8'hFF);
        chk(8'(o_regulators), 8'h15);
        $display("reset test done");
        @(posedge i_clock);
        i_active_template <= 8'hA5;
        cyc(3);
        chk(o_clock_gate_en, 8'hA5);
        chk(o_bias_en, 8'hA5);
        // A low clock enable freezes all state, so a template edit waits for it.
        @(posedge i_clock);
        i_clock_enable <= 1'b0;
        i_active_template <= 8'hA7;
        cyc(3);
        chk(o_clock_gate_en, 8'hA5);
        @(posedge i_clock);
        i_clock_enable <= 1'b1;
        cyc(2);
        chk(o_clock_gate_en, 8'hA7);
        @(posedge i_clock);
        i_cpu_self_off <= 1'b1;
        @(posedge i_clock);
        i_cpu_self_off <= 1'b0;
        cyc(2);
        chk(8'(o_cpu_enable), 8'h00);
        req(PMC_ALT_ACTIVE);
        chk(8'(o_mode), 8'h01);
        chk(o_clock_gate_en, 8'hFC);
        $display("active test done");
        // Low-power entry without valid I/O supplies must be ignored.
        @(posedge i_clock);
        i_io_supply_valid <= 1'b0;
        cyc(4);
        req(PMC_SLEEP);
        chk(8'(o_mode), 8'h01);
        @(posedge i_clock);
        i_io_supply_valid <= 1'b1;
        i_active_template <= 8'hA4;
        i_wake_enable <= 8'hFE;
        cyc(4);
        req(PMC_SLEEP);
        chk(8'(o_mode), 8'h02);
        chk(o_clock_gate_en, 8'h00);
        chk(8'({o_regulators.digital_buzz, o_regulators.analog_buzz}), 8'h03);
        chk(8'({o_slow_clock_run, o_rtc_run}), 8'h03);
        @(posedge i_clock);
        i_int_wake <= 8'h01;
        cyc(6);
        chk(8'(o_mode), 8'h02);
        @(posedge i_clock);
        i_int_wake <= 8'h00;
        i_periodic_wake_timer <= 1'b1;
        cyc(3);
        chk(8'(o_resuming), 8'h01);
        to_active();
        chk(8'(n), 8'(RESUME));
        cyc(2);
        chk(8'(o_cpu_enable), 8'h01);
        $display("sleep test done");
        @(posedge i_clock);
        i_periodic_wake_timer <= 1'b0;
        req(PMC_HIBERNATE);
        chk(8'(o_mode), 8'h03);
        chk(8'({o_all_clocks_stop, o_pin_wake_only}), 8'h03);
        chk(8'({o_regulators.digital_on, o_regulators.analog_on,
            o_regulators.hibernate_on}), 8'h01);
        @(posedge i_clock);
        i_periodic_wake_timer <= 1'b1;
        cyc(6);
        chk(8'(o_mode), 8'h03);
        @(posedge i_clock);
        i_periodic_wake_timer <= 1'b0;
        i_pin_interrupt_unit <= 1'b1;
        cyc(2);
        chk(8'(o_wake_event), 8'h01);
        to_active();
        chk(8'(n < 10), 8'h01);
        cyc(2);
        chk(8'(o_cpu_enable), 8'h01);
        $display("hibernate test done");
        // Internal regulators may only be shut off under external supply.
        @(posedge i_clock);
        i_pin_interrupt_unit <= 1'b0;
        i_reg_disable <= 1'b1;
        cyc(5);
        chk(8'({o_regulators.digital_on, o_regulators.analog_on}), 8'h03);
        @(posedge i_clock);
        i_ext_core_supply <= 1'b1;
        cyc(5);
        chk(8'({o_regulators.digital_on, o_regulators.analog_on}), 8'h00);
        $display("regulator test done");
        conclude();
    end

    // Watchdog: the sequence needs well under a thousand cycles.
    initial begin
        #20000;
        bad_count++;
        conclude();
    end
endmodule : test_pmc_controller
